/* design/psa_pause_source_regs.sv */
// Behaviour
// R1: Register at index 132 holds station address bits 15:0, reset zero.
// R2: Register at index 133 holds station address bits 31:16, reset zero.
// R3: Register at index 134 holds station address bits 47:32, reset zero.
// R4: Per-port bit 9 acts only while pause use is selected.
// R5: Per-port bit 0: all ports send the full address unchanged.
// R6: Per-port bit 1: port n sends address bits 47:3 with n low.
// R7: Usage bits 8:7: 00 unused, 01/11 pause, 10 lock or monitor.
// R8: Bits 6:3 hold the lock filtering identifier, read-write.
// R9: Bits 2:0 name the assigned port or monitor port, read-write.
// R10: Option bits 15:10 read zero, writes to them ignored.
`timescale 1ns/100ps
`include "psa_cfg.svh"

module psa_pause_source_regs
   import psa_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [13:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [13:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [47:0]      stationAddressValue,
   output logic [1:0]       addressUsageSelect,
   output logic [3:0]       lockFilterId,
   output logic [2:0]       targetPortField,
   output logic             pauseAddrValid,
   output logic [47:0]      pauseSrcAddr [`PSA_NUM_PORTS]
);

   logic        wrStrobe;
   logic [11:0] wrIndex;
   logic [31:0] wrData;
   logic [3:0]  wrStrb;
   logic        wrHit;
   logic [11:0] rdIndex;
   logic [15:0] rdData;
   logic        rdHit;

   logic [15:0] addrLowD, addrLowQ, addrMidD, addrMidQ, addrHighD, addrHighQ;
   logic [15:0] optionsD, optionsQ;
   psa_config_s cfg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave

   psa_axil_slave uSlave (
      .clock         (clock),
      .reset_n       (reset_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wrStrobe      (wrStrobe),
      .wrIndex       (wrIndex),
      .wrData        (wrData),
      .wrStrb        (wrStrb),
      .wrHit         (wrHit),
      .rdIndex       (rdIndex),
      .rdData        (rdData),
      .rdHit         (rdHit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic isMapped(input logic [11:0] idx);
      isMapped = (idx == `PSA_IDX_ADDR_LOW) || (idx == `PSA_IDX_ADDR_MID) ||
                 (idx == `PSA_IDX_ADDR_HIGH) || (idx == `PSA_IDX_OPTIONS);
   endfunction

   // Byte lanes beyond the low two carry nothing
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      merge = old;
      if (strb[0]) begin
         merge[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merge[15:8] = data[15:8];
      end
   endfunction

   assign wrHit = isMapped(wrIndex);
   assign rdHit = isMapped(rdIndex);

   always_comb begin
      addrLowD  = addrLowQ;
      addrMidD  = addrMidQ;
      addrHighD = addrHighQ;
      optionsD  = optionsQ;
      if (wrStrobe) begin
         unique case (wrIndex)
            `PSA_IDX_ADDR_LOW:  addrLowD  = merge(addrLowQ, wrData, wrStrb);   // [R1]
            `PSA_IDX_ADDR_MID:  addrMidD  = merge(addrMidQ, wrData, wrStrb);   // [R2]
            `PSA_IDX_ADDR_HIGH: addrHighD = merge(addrHighQ, wrData, wrStrb);  // [R3]
            `PSA_IDX_OPTIONS:   optionsD  = merge(optionsQ, wrData, wrStrb)
                                            & `PSA_OPT_MASK;                     // [R10]
            default: ;
         endcase
      end
   end

   always_comb begin
      rdData = 16'h0000;
      unique case (rdIndex)
         `PSA_IDX_ADDR_LOW:  rdData = addrLowQ;   // [R1]
         `PSA_IDX_ADDR_MID:  rdData = addrMidQ;   // [R2]
         `PSA_IDX_ADDR_HIGH: rdData = addrHighQ;  // [R3]
         `PSA_IDX_OPTIONS:   rdData = optionsQ & `PSA_OPT_MASK;   // [R10]
         default:            rdData = 16'h0000;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         addrLowQ  <= `PSA_RST_ADDR;
         addrMidQ  <= `PSA_RST_ADDR;
         addrHighQ <= `PSA_RST_ADDR;
         optionsQ  <= `PSA_RST_OPTIONS;
      end else begin
         addrLowQ  <= addrLowD;
         addrMidQ  <= addrMidD;
         addrHighQ <= addrHighD;
         optionsQ  <= optionsD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration fan-out

   always_comb begin
      cfg.stationAddress       = {addrHighQ, addrMidQ, addrLowQ};
      cfg.options.pausePerPort = optionsQ[`PSA_OPT_PERPORT];                         // [R4]
      cfg.options.usageSelect  = psa_usage_e'(optionsQ[`PSA_OPT_SEL_MSB:`PSA_OPT_SEL_LSB]); // [R7]
      cfg.options.lockFilterId = optionsQ[`PSA_OPT_FID_MSB:`PSA_OPT_FID_LSB];        // [R8]
      cfg.options.targetPort   = optionsQ[`PSA_OPT_PORT_MSB:`PSA_OPT_PORT_LSB];      // [R9]
   end

   assign stationAddressValue = cfg.stationAddress;
   assign addressUsageSelect  = cfg.options.usageSelect;
   assign lockFilterId        = cfg.options.lockFilterId;
   assign targetPortField     = cfg.options.targetPort;

   psa_pause_addr_gen uGen (
      .clock          (clock),
      .reset_n        (reset_n),
      .cfg            (cfg),
      .pauseAddrValid (pauseAddrValid),
      .pauseSrcAddr   (pauseSrcAddr)
   );

endmodule

/* design/psa_cfg.svh */
`ifndef PSA_CFG_SVH
`define PSA_CFG_SVH

// Register indices as printed; byte address is four times the index
`define PSA_IDX_ADDR_LOW   12'h132
`define PSA_IDX_ADDR_MID   12'h133
`define PSA_IDX_ADDR_HIGH  12'h134
`define PSA_IDX_OPTIONS    12'h135

// Option register field positions
`define PSA_OPT_PORT_LSB   0
`define PSA_OPT_PORT_MSB   2
`define PSA_OPT_FID_LSB    3
`define PSA_OPT_FID_MSB    6
`define PSA_OPT_SEL_LSB    7
`define PSA_OPT_SEL_MSB    8
`define PSA_OPT_PERPORT    9
`define PSA_OPT_MASK       16'h03FF

// Reset values
`define PSA_RST_ADDR       16'h0000
`define PSA_RST_OPTIONS    16'h0000

// Port count
`define PSA_NUM_PORTS      6

// AXI responses
`define PSA_RESP_OKAY      2'h0
`define PSA_RESP_SLVERR    2'h2

`endif

/* design/psa_pkg.sv */
package psa_pkg;

   typedef enum logic [1:0] {
      PSA_USE_NONE  = 2'h0,
      PSA_USE_PAUSE = 2'h1,
      PSA_USE_LOCK  = 2'h2,
      PSA_USE_PAUSE2 = 2'h3
   } psa_usage_e;

   typedef struct packed {
      logic       pausePerPort;
      psa_usage_e usageSelect;
      logic [3:0] lockFilterId;
      logic [2:0] targetPort;
   } psa_options_s;

   typedef struct packed {
      logic [47:0]  stationAddress;
      psa_options_s options;
   } psa_config_s;

endpackage

/* design/psa_pause_addr_gen.sv */
`timescale 1ns/100ps
`include "psa_cfg.svh"

module psa_pause_addr_gen
   import psa_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire psa_config_s cfg,
   output logic             pauseAddrValid,
   output logic [47:0]      pauseSrcAddr [`PSA_NUM_PORTS]
);

   logic             validD;
   logic             validQ;
   logic [47:0]      addrD [`PSA_NUM_PORTS];
   logic [47:0]      addrQ [`PSA_NUM_PORTS];

   always_comb begin
      validD = (cfg.options.usageSelect == PSA_USE_PAUSE) ||
               (cfg.options.usageSelect == PSA_USE_PAUSE2);   // [R7]
   end

   genvar p;
   generate
      for (p = 0; p < `PSA_NUM_PORTS; p++) begin : gPort
         always_comb begin
            // Per-port substitution only matters while pause use is selected
            if (validD && cfg.options.pausePerPort) begin   // [R4]
               addrD[p] = {cfg.stationAddress[47:3], 3'(p)};   // [R6]
            end else begin
               addrD[p] = cfg.stationAddress;   // [R5]
            end
         end
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               addrQ[p] <= 48'h0000_0000_0000;
            end else begin
               addrQ[p] <= addrD[p];
            end
         end
         assign pauseSrcAddr[p] = addrQ[p];
      end
   endgenerate

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         validQ <= 1'b0;
      end else begin
         validQ <= validD;
      end
   end

   assign pauseAddrValid = validQ;

endmodule

/* design/psa_axil_slave.sv */
`timescale 1ns/100ps
`include "psa_cfg.svh"

module psa_axil_slave (
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [13:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [13:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wrStrobe,
   output logic [11:0]      wrIndex,
   output logic [31:0]      wrData,
   output logic [3:0]       wrStrb,
   input  wire logic        wrHit,
   output logic [11:0]      rdIndex,
   input  wire logic [15:0] rdData,
   input  wire logic        rdHit
);

   logic        awHeldD, awHeldQ, wHeldD, wHeldQ, bValidD, bValidQ;
   logic        rValidD, rValidQ;
   logic [11:0] awIdxD, awIdxQ;
   logic [31:0] wDataD, wDataQ;
   logic [3:0]  wStrbD, wStrbQ;
   logic [1:0]  bRespD, bRespQ, rRespD, rRespQ;
   logic [31:0] rDataD, rDataQ;
   logic        doWrite;

   ////////////////////////////////////////////////////////////////////////////
   // Write path: address and data taken in either order, one write in flight

   assign s_axi_awready = !awHeldQ && !bValidQ;
   assign s_axi_wready  = !wHeldQ && !bValidQ;
   assign s_axi_bvalid  = bValidQ;
   assign s_axi_bresp   = bRespQ;

   always_comb begin
      awHeldD = awHeldQ;
      wHeldD  = wHeldQ;
      awIdxD  = awIdxQ;
      wDataD  = wDataQ;
      wStrbD  = wStrbQ;
      bValidD = bValidQ;
      bRespD  = bRespQ;
      if (s_axi_awvalid && s_axi_awready) begin
         awHeldD = 1'b1;
         awIdxD  = s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeldD = 1'b1;
         wDataD = s_axi_wdata;
         wStrbD = s_axi_wstrb;
      end
      doWrite = awHeldQ && wHeldQ;
      if (doWrite) begin
         awHeldD = 1'b0;
         wHeldD  = 1'b0;
         bValidD = 1'b1;
         bRespD  = wrHit ? `PSA_RESP_OKAY : `PSA_RESP_SLVERR;
      end else if (bValidQ && s_axi_bready) begin
         bValidD = 1'b0;
      end
   end

   assign wrStrobe = doWrite;
   assign wrIndex  = awIdxQ;
   assign wrData   = wDataQ;
   assign wrStrb   = wStrbQ;

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   assign s_axi_arready = !rValidQ;
   assign s_axi_rvalid  = rValidQ;
   assign s_axi_rdata   = rDataQ;
   assign s_axi_rresp   = rRespQ;
   assign rdIndex       = s_axi_araddr[13:2];

   always_comb begin
      rValidD = rValidQ;
      rDataD  = rDataQ;
      rRespD  = rRespQ;
      if (s_axi_arvalid && s_axi_arready) begin
         rValidD = 1'b1;
         rDataD  = {16'h0000, rdHit ? rdData : 16'h0000};
         rRespD  = rdHit ? `PSA_RESP_OKAY : `PSA_RESP_SLVERR;
      end else if (rValidQ && s_axi_rready) begin
         rValidD = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         awHeldQ <= 1'b0;
         wHeldQ  <= 1'b0;
         awIdxQ  <= 12'h000;
         wDataQ  <= 32'h0000_0000;
         wStrbQ  <= 4'h0;
         bValidQ <= 1'b0;
         bRespQ  <= 2'h0;
         rValidQ <= 1'b0;
         rDataQ  <= 32'h0000_0000;
         rRespQ  <= 2'h0;
      end else begin
         awHeldQ <= awHeldD;
         wHeldQ  <= wHeldD;
         awIdxQ  <= awIdxD;
         wDataQ  <= wDataD;
         wStrbQ  <= wStrbD;
         bValidQ <= bValidD;
         bRespQ  <= bRespD;
         rValidQ <= rValidD;
         rDataQ  <= rDataD;
         rRespQ  <= rRespD;
      end
   end

endmodule

/* dv/psa_pause_source_regs_monitor.sv */
`timescale 1ns/100ps
`include "psa_cfg.svh"

module psa_pause_source_regs_monitor (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [47:0] stationAddressValue,
   input wire logic [1:0]  addressUsageSelect,
   input wire logic [3:0]  lockFilterId,
   input wire logic [2:0]  targetPortField,
   input wire logic        pauseAddrValid,
   input wire logic [47:0] pauseSrcAddr [`PSA_NUM_PORTS]
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_wr_answer: assert property (s_wr_taken |=> s_b_late)
      else $error("write response not two cycles after request");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after request");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   // Configuration only moves with a write completion
   a_cfg_on_write: assert property (!$stable({stationAddressValue, addressUsageSelect,
      lockFilterId, targetPortField}) |-> $rose(s_axi_bvalid)) else $error("config moved alone");
   a_pause_valid: assert property (pauseAddrValid == $past(addressUsageSelect[0]))
      else $error("pause valid does not follow usage select");
   for (genvar k = 0; k < `PSA_NUM_PORTS; k++) begin : g_port
      a_port_high: assert property (
         pauseSrcAddr[k][47:3] == $past(stationAddressValue[47:3]))
         else $error("pause source upper bits wrong");
      a_port_low: assert property (
         pauseSrcAddr[k][2:0] == $past(stationAddressValue[2:0])
         || (pauseAddrValid && pauseSrcAddr[k][2:0] == 3'(k))) else $error("port bits wrong");
   end
endmodule

/* dv/tb_psa_pause_source_regs.sv */
`timescale 1ns/100ps
`include "psa_cfg.svh"

module tb_psa_pause_source_regs;
   logic        clock = 1'h0;
   logic        reset_n = 1'h0;
   logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb = '0, lockFilterId;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, pauseAddrValid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, addressUsageSelect, rsp;
   logic [2:0]  targetPortField;
   logic [47:0] stationAddressValue, sta;
   logic [47:0] pauseSrcAddr [`PSA_NUM_PORTS];
   int          errTotal = 0, nTests = 0;

   psa_pause_source_regs u_psa_pause_source_regs (
      .clock               (clock),
      .reset_n             (reset_n),
      .s_axi_awaddr        (s_axi_awaddr),
      .s_axi_awvalid       (s_axi_awvalid),
      .s_axi_awready       (s_axi_awready),
      .s_axi_wdata         (s_axi_wdata),
      .s_axi_wstrb         (s_axi_wstrb),
      .s_axi_wvalid        (s_axi_wvalid),
      .s_axi_wready        (s_axi_wready),
      .s_axi_bresp         (s_axi_bresp),
      .s_axi_bvalid        (s_axi_bvalid),
      .s_axi_bready        (s_axi_bready),
      .s_axi_araddr        (s_axi_araddr),
      .s_axi_arvalid       (s_axi_arvalid),
      .s_axi_arready       (s_axi_arready),
      .s_axi_rdata         (s_axi_rdata),
      .s_axi_rresp         (s_axi_rresp),
      .s_axi_rvalid        (s_axi_rvalid),
      .s_axi_rready        (s_axi_rready),
      .stationAddressValue (stationAddressValue),
      .addressUsageSelect  (addressUsageSelect),
      .lockFilterId        (lockFilterId),
      .targetPortField     (targetPortField),
      .pauseAddrValid      (pauseAddrValid),
      .pauseSrcAddr        (pauseSrcAddr)
   );

   always #2.5 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      nTests++;
      if (seen !== exp) begin
         errTotal++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      if (errTotal == 0 && nTests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Address and data offered together, each released once taken
   task wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] st);
      logic a, w;
      a = 0;
      w = 0;
      @(posedge clock);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(a && w)) begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) begin
            a = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 0;
         end
      end
      do @(posedge clock); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask

   task rd(input logic [11:0] idx);
      @(posedge clock);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clock); while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clock);
      reset_n <= 1;
      for (int i = 0; i < 4; i++) begin
         rd(12'(`PSA_IDX_ADDR_LOW + i));
         chk(rdv, 0);
      end
      sta = 48'hA5C3_1E2D_F0B7;
      for (int i = 0; i < 3; i++) begin
         wr(12'(`PSA_IDX_ADDR_LOW + i), {16'hFFFF, sta[16*i +: 16]}, 4'hF);
         chk(rsp, `PSA_RESP_OKAY);
         rd(12'(`PSA_IDX_ADDR_LOW + i));
         chk(rdv, {16'h0000, sta[16*i +: 16]});
      end
      chk(stationAddressValue, sta);
      // Only byte lane 0 enabled
      wr(`PSA_IDX_ADDR_LOW, 32'h0000_1234, 4'h1);
      rd(`PSA_IDX_ADDR_LOW);
      chk(rdv, 32'h0000_F034);
      chk(rsp, `PSA_RESP_OKAY);
      wr(`PSA_IDX_ADDR_LOW, {16'h0000, sta[15:0]}, 4'hF);
      wr(`PSA_IDX_OPTIONS, 32'hFFFF_FD55, 4'hF);
      rd(`PSA_IDX_OPTIONS);
      chk(rdv, 32'h0000_0155);
      chk(lockFilterId, 4'hA);
      chk(targetPortField, 3'h5);
      chk(addressUsageSelect, 2'h2);
      // Every usage code with the per-port bit off and on
      for (int m = 0; m < 8; m++) begin
         wr(`PSA_IDX_OPTIONS, 32'(m) << 7, 4'hF);
         repeat (3) @(posedge clock);
         chk(pauseAddrValid, m[0]);
         for (int k = 0; k < `PSA_NUM_PORTS; k++)
            chk(pauseSrcAddr[k], (m[2] && m[0]) ? {sta[47:3], 3'(k)} : sta);
      end
      wr(12'h136, 32'h0000_FFFF, 4'hF);
      chk(rsp, `PSA_RESP_SLVERR);
      rd(12'h136);
      chk(rsp, `PSA_RESP_SLVERR);
      chk(rdv, 0);
      rd(`PSA_IDX_ADDR_LOW);
      chk(rdv, {16'h0000, sta[15:0]});
      // Second reset in mid-run
      @(posedge clock);
      reset_n <= 0;
      repeat (2) @(posedge clock);
      chk(stationAddressValue, 0);
      chk(pauseAddrValid, 0);
      reset_n <= 1;
      rd(`PSA_IDX_OPTIONS);
      chk(rdv, 0);
      end_of_test;
   end

   // Whole run needs under two hundred cycles
   initial begin
      repeat (5000) @(posedge clock);
      errTotal++;
      end_of_test;
   end
endmodule

bind psa_pause_source_regs psa_pause_source_regs_monitor u_psa_pause_source_regs_monitor (
   .clock(clock), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .stationAddressValue(stationAddressValue), .addressUsageSelect(addressUsageSelect),
   .lockFilterId(lockFilterId), .targetPortField(targetPortField),
   .pauseAddrValid(pauseAddrValid), .pauseSrcAddr(pauseSrcAddr));
